// ### spdsr_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial port block.
// Assumes byte addresses on an 8-bit register address port, one 32-bit word per register.
`ifndef SPDSR_DEFS_SVH
`define SPDSR_DEFS_SVH
`define SPDSR_A_CTRL0 8'h00
`define SPDSR_A_CTRL1 8'h04
`define SPDSR_A_DATA 8'h08
`define SPDSR_A_STAT 8'h0C
`define SPDSR_A_PRESC 8'h10
`define SPDSR_A_MASK 8'h14
`define SPDSR_A_RAW 8'h18
`define SPDSR_A_MIS 8'h1C
`define SPDSR_A_CLR 8'h20
`define SPDSR_CTRL0_RST 32'h0000001F
`define SPDSR_CTRL1_RST 32'h00000000
`define SPDSR_PRESC_RST 8'h00
`define SPDSR_MASK_RST 6'h00
`define SPDSR_C1_EN 1
`define SPDSR_C1_RXTH_LO 7
`define SPDSR_C1_TXTH_LO 10
`define SPDSR_C0_SCR_LO 8
`define SPDSR_FIFO_DEPTH 8
`define SPDSR_RX_TMO_HALFBITS 16'h0040
`define SPDSR_MIN_FSIZE_M1 5'h03
`endif

// ### spdsr_pkg.sv
// Types shared by the serial port block: bus carrier, serial pins, shifter states.
// Constants live in spdsr_defs.svh.
package spdsr_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } spdsr_bus_req_t;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } spdsr_ser_t;
  typedef enum logic [1:0] {
    SPDSR_IDLE = 2'b00,
    SPDSR_SHIFT = 2'b01,
    SPDSR_LAST = 2'b11
  } spdsr_state_t;
endpackage : spdsr_pkg

// ### spdsr_top.sv
// Serial port controller: data port, status, bit-rate prescaler, interrupt mask and status.
// Assumes a single-cycle register master on mclk and a serial slave on the sclk/mosi/miso pins.
// Notes on behaviour
// [RULE_01] Data port read pops oldest receive entry; write pushes transmit FIFO.
// [RULE_02] Software right-justifies transmit data narrower than 32 bits.
// [RULE_03] Bits above frame size ignored on transmit; receive data aligned to bit zero.
// [RULE_04] Status bit 0 shows transmit FIFO empty; resets to one.
// [RULE_05] Status bit 1 shows transmit FIFO has space; resets to one.
// [RULE_06] Status bit 2 shows receive FIFO holds data; resets to zero.
// [RULE_07] Status bit 3 shows receive FIFO full; resets to zero.
// [RULE_08] Status bit 4 busy while shifting or transmit FIFO not empty.
// [RULE_09] Status bits above four read zero; status ignores writes.
// [RULE_10] Software programs an even prescale divisor from 2 to 254.
// [RULE_11] Bit rate is clock over divisor times one plus rate factor.
// [RULE_12] Mask holds six source enables at bits 0 to 5.
// [RULE_13] All mask bits reset to zero.
// [RULE_14] Overrun raised when a frame arrives with receive FIFO full.
// [RULE_15] Timeout raised when receive data stays unread for the timeout period.
// [RULE_16] Raw status shows six unmasked sources, read-only, resets zero; here bit 4 has no source and reads zero.
// [RULE_17] Masked status is raw status ANDed with mask, read-only.
// [RULE_18] Transmit FIFO empty source sits at bit 5.
// [RULE_19] Clear register bits 0..2 clear overrun, timeout, underrun; no underrun source exists here, so bit 2 is ignored.
// [RULE_20] Receive level threshold 1, 4 or 8 entries by 3-bit code.
// [RULE_21] Port works only while enable bit is one; resets disabled.
// [RULE_22] One interrupt output is OR of the six masked bits.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "spdsr_defs.svh"

module spdsr_fifo (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [31:0] wdata,
  output logic [31:0] head,
  output logic [3:0] count,
  output logic full,
  output logic empty
);
  logic [31:0] mem [0:`SPDSR_FIFO_DEPTH-1];
  logic [2:0] wp_r;
  logic [2:0] rp_r;
  logic [3:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == 4'(`SPDSR_FIFO_DEPTH));
  assign empty = (cnt_r == 4'h0);
  assign count = cnt_r;
  assign head = mem[rp_r];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wp_r] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 3'h1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 3'h1;
      end
      cnt_r <= cnt_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule : spdsr_fifo

module spdsr_top
  import spdsr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire spdsr_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output spdsr_ser_t ser_out,
  input wire logic ser_miso,
  output logic irq
);
  logic [31:0] ctrl0_r;
  logic [31:0] ctrl1_r;
  logic [7:0] presc_r;
  logic [5:0] mask_r;
  logic ovr_r;
  logic tmo_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic miso_m_r;
  logic miso_s_r;
  spdsr_state_t state_r;
  logic [15:0] div_cnt_r;
  logic sclk_r;
  logic cs_n_r;
  logic [31:0] tx_sh_r;
  logic [31:0] rx_sh_r;
  logic [5:0] bit_cnt_r;
  logic [15:0] tmo_cnt_r;
  logic drained_r;

  logic [31:0] tx_head;
  logic [31:0] rx_head;
  logic [3:0] tx_count;
  logic [3:0] rx_count;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic wr_data;
  logic rd_data;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic port_en;
  logic [4:0] fsize_m1;
  logic [5:0] fsize;
  logic [6:0] div_half;
  logic [15:0] half_m1;
  logic tick;
  logic frame_end;
  logic [3:0] rx_thr;
  logic [3:0] tx_thr;
  logic [5:0] raw;
  logic [5:0] masked;
  logic [4:0] status;

  assign wr_data = bus_req.wr && (bus_req.addr == `SPDSR_A_DATA);
  assign rd_data = bus_req.rd && (bus_req.addr == `SPDSR_A_DATA);
  assign port_en = ctrl1_r[`SPDSR_C1_EN];
  assign fsize_m1 = (ctrl0_r[4:0] < `SPDSR_MIN_FSIZE_M1) ? `SPDSR_MIN_FSIZE_M1 : ctrl0_r[4:0];
  assign fsize = {1'b0, fsize_m1} + 6'h01;

  // [RULE_01] data port pushes and pops
  assign tx_push = wr_data;
  assign tx_pop = port_en && !tx_empty && ((state_r == SPDSR_IDLE) || (tick && frame_end));

  spdsr_fifo u_tx_fifo (
    .mclk(mclk), .sys_rst(sys_rst), .push(tx_push), .pop(tx_pop), .wdata(bus_req.wdata),
    .head(tx_head), .count(tx_count), .full(tx_full), .empty(tx_empty)
  );

  spdsr_fifo u_rx_fifo (
    .mclk(mclk), .sys_rst(sys_rst), .push(rx_push), .pop(rd_data), .wdata(rx_sh_r),
    .head(rx_head), .count(rx_count), .full(rx_full), .empty(rx_empty)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= ser_miso;
      miso_s_r <= miso_m_r;
    end
  end

  // [RULE_11] half bit period is divisor/2 times one plus rate factor
  assign div_half = (presc_r[7:1] == 7'h00) ? 7'h01 : presc_r[7:1];
  assign half_m1 = ({9'h000, div_half} * (16'h0001 + {8'h00, ctrl0_r[`SPDSR_C0_SCR_LO +: 8]}))
    - 16'h0001;
  assign tick = (state_r != SPDSR_IDLE) && (div_cnt_r == half_m1);
  assign frame_end = sclk_r && (bit_cnt_r == fsize);

  always_ff @(posedge mclk) begin
    if (sys_rst || (state_r == SPDSR_IDLE) || tick) begin
      div_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // [RULE_21] shifter runs only while enabled
  always_ff @(posedge mclk) begin
    if (sys_rst || !port_en) begin
      state_r <= SPDSR_IDLE;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      tx_sh_r <= 32'h00000000;
      rx_sh_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
    end else if (tx_pop) begin
      // [RULE_03] frame left-aligned so upper bits never leave
      state_r <= SPDSR_SHIFT;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b0;
      tx_sh_r <= tx_head << (6'h20 - fsize);
      rx_sh_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
    end else if (tick) begin
      if (!sclk_r) begin
        sclk_r <= 1'b1;
        // [RULE_03] receive shifts in at bit zero
        rx_sh_r <= {rx_sh_r[30:0], miso_s_r};
        bit_cnt_r <= bit_cnt_r + 6'h01;
        state_r <= (bit_cnt_r + 6'h01 == fsize) ? SPDSR_LAST : SPDSR_SHIFT;
      end else if (frame_end) begin
        sclk_r <= 1'b0;
        cs_n_r <= 1'b1;
        state_r <= SPDSR_IDLE;
      end else begin
        sclk_r <= 1'b0;
        tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      end
    end
  end

  assign rx_push = tick && frame_end;

  // [RULE_15] timeout counts clock cycles of unread receive data
  always_ff @(posedge mclk) begin
    if (sys_rst || rx_empty || rd_data || rx_push) begin
      tmo_cnt_r <= 16'h0000;
    end else if (tmo_cnt_r != `SPDSR_RX_TMO_HALFBITS) begin
      tmo_cnt_r <= tmo_cnt_r + 16'h0001;
    end
  end

  // [RULE_19] sticky sources, set wins over clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ovr_r <= 1'b0;
      tmo_r <= 1'b0;
    end else begin
      // [RULE_14] frame arriving into a full receive FIFO
      if (rx_push && rx_full) begin
        ovr_r <= 1'b1;
      end else if (bus_req.wr && (bus_req.addr == `SPDSR_A_CLR) && bus_req.wdata[0]) begin
        ovr_r <= 1'b0;
      end
      if (tmo_cnt_r == `SPDSR_RX_TMO_HALFBITS - 16'h0001) begin
        tmo_r <= 1'b1;
      end else if (bus_req.wr && (bus_req.addr == `SPDSR_A_CLR) && bus_req.wdata[1]) begin
        tmo_r <= 1'b0;
      end
    end
  end

  // [RULE_20] level thresholds from 3-bit codes
  function automatic logic [3:0] spdsr_thr(input logic [2:0] code);
    logic [3:0] t;
    t = 4'h1;
    if (code == 3'b001) begin
      t = 4'h4;
    end else if (code == 3'b010) begin
      t = 4'h8;
    end
    return t;
  endfunction : spdsr_thr

  assign rx_thr = spdsr_thr(ctrl1_r[`SPDSR_C1_RXTH_LO +: 3]);
  assign tx_thr = spdsr_thr(ctrl1_r[`SPDSR_C1_TXTH_LO +: 3]);

  // [RULE_18] bit 5 latches as the last transmit entry leaves and drops on refill
  always_ff @(posedge mclk) begin
    drained_r <= !sys_rst && ((tx_pop && (tx_count == 4'h1) && !tx_push)
      || (drained_r && tx_empty));
  end
  // [RULE_16] raw sources, all clear after reset
  assign raw = {drained_r, 1'b0, (tx_count >= tx_thr), (rx_count >= rx_thr), tmo_r, ovr_r};
  // [RULE_17] masked view
  assign masked = raw & mask_r;

  // [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_08] status flags
  assign status = {(state_r != SPDSR_IDLE) || !tx_empty, rx_full, !rx_empty, !tx_full, tx_empty};

  // [RULE_13] mask resets cleared; [RULE_12] six enables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl0_r <= `SPDSR_CTRL0_RST;
      ctrl1_r <= `SPDSR_CTRL1_RST;
      presc_r <= `SPDSR_PRESC_RST;
      mask_r <= `SPDSR_MASK_RST;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `SPDSR_A_CTRL0: ctrl0_r <= {16'h0000, bus_req.wdata[15:0]};
        `SPDSR_A_CTRL1: ctrl1_r <= {19'h00000, bus_req.wdata[12:7], 5'h00, bus_req.wdata[1], 1'b0};
        `SPDSR_A_PRESC: presc_r <= bus_req.wdata[7:0];
        `SPDSR_A_MASK: mask_r <= bus_req.wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // [RULE_09] read mux; upper status bits zero, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (sys_rst || !bus_req.rd) begin
      rdata_r <= 32'h00000000;
    end else begin
      unique case (bus_req.addr)
        `SPDSR_A_CTRL0: rdata_r <= ctrl0_r;
        `SPDSR_A_CTRL1: rdata_r <= ctrl1_r;
        `SPDSR_A_DATA: rdata_r <= rx_empty ? 32'h00000000 : rx_head;
        `SPDSR_A_STAT: rdata_r <= {27'h0000000, status};
        `SPDSR_A_PRESC: rdata_r <= {24'h000000, presc_r};
        `SPDSR_A_MASK: rdata_r <= {26'h0000000, mask_r};
        `SPDSR_A_RAW: rdata_r <= {26'h0000000, raw};
        `SPDSR_A_MIS: rdata_r <= {26'h0000000, masked};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // [RULE_22] single request line
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |masked;
    end
  end

  assign bus_rdata = rdata_r;
  assign irq = irq_r;
  assign ser_out = '{sclk: sclk_r, mosi: tx_sh_r[31], cs_n: cs_n_r};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_dp_write_push: assert property ( // RULE_01
    wr_data && tx_empty && port_en |=> !tx_empty || (state_r == SPDSR_SHIFT))
    else $error("data port write did not reach transmit FIFO");
  a_dp_read_pop: assert property ( // RULE_01
    rd_data && !rx_empty && !rx_push |=> rx_count == $past(rx_count) - 4'h1)
    else $error("data port read did not pop receive FIFO");
  a_stat_tx_empty: assert property ( // RULE_04
    bus_req.rd && (bus_req.addr == `SPDSR_A_STAT) |=> bus_rdata[1:0] == {!$past(tx_full), $past(tx_empty)})
    else $error("transmit flags wrong in status");
  a_stat_rx_flags: assert property ( // RULE_06
    bus_req.rd && (bus_req.addr == `SPDSR_A_STAT) |=> bus_rdata[3:2] == {$past(rx_full), !$past(rx_empty)})
    else $error("receive flags wrong in status");
  a_stat_busy_hi: assert property ( // RULE_08
    bus_req.rd && (bus_req.addr == `SPDSR_A_STAT) && (state_r != SPDSR_IDLE) |=> bus_rdata[4])
    else $error("busy flag low while shifting");
  a_stat_upper_zero: assert property ( // RULE_09
    bus_req.rd && (bus_req.addr == `SPDSR_A_STAT) |=> bus_rdata[31:5] == 27'h0000000)
    else $error("status upper bits not zero");
  a_ovr_raise: assert property ( // RULE_14
    rx_push && rx_full ##1 !bus_req.wr |-> ovr_r [*2])
    else $error("overrun not raised");
  a_ovr_clear: assert property ( // RULE_19
    bus_req.wr && (bus_req.addr == `SPDSR_A_CLR) && bus_req.wdata[0] && !rx_push |=> !ovr_r)
    else $error("overrun not cleared");
  a_mis_value: assert property ( // RULE_17
    bus_req.rd && (bus_req.addr == `SPDSR_A_MIS) |=> bus_rdata[5:0] == ($past(raw) & $past(mask_r)))
    else $error("masked status mismatch");
  a_irq_follows: assert property ( // RULE_22
    1'b1 |=> irq == |$past(masked))
    else $error("interrupt line mismatch");
  a_disabled_idle: assert property ( // RULE_21
    !port_en |=> (state_r == SPDSR_IDLE) && ser_out.cs_n)
    else $error("shifter active while disabled");
  a_tick_spacing: assert property ( // RULE_11
    tick && (half_m1 == 16'h0000) && (state_r == SPDSR_SHIFT) |=> tick || (state_r != SPDSR_SHIFT))
    else $error("bit clock divider too slow");

  c_frame_done: cover property (rx_push && !rx_full);
  c_overrun: cover property (rx_push && rx_full);
  c_timeout: cover property ($rose(tmo_r));
  c_irq: cover property ($rose(irq));
endmodule : spdsr_top

// ### spdsr_slave.sv
// Serial slave model for the port bench: mode 0, MSB first, 8-bit frames.
// Assumes the master keeps cs_n low across a burst; replies 0xC0 plus frame index.
`timescale 1ns/1ps
module spdsr_slave
  import spdsr_pkg::*;
(
  input wire logic mclk,
  input wire spdsr_ser_t ser,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] idx;
  logic [2:0] cnt;
  logic sclk_q;
  logic cs_q;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    idx = 8'h00;
    cnt = 3'h0;
    sclk_q = 1'b0;
    cs_q = 1'b1;
  end
  always @(posedge mclk) begin
    sclk_q <= ser.sclk;
    cs_q <= ser.cs_n;
    // Falling edge first: the last one arrives together with cs_n rising
    if (sclk_q && !ser.sclk) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        got <= rx_sh;
        idx <= idx + 8'h01;
        tx_sh <= 8'hC1 + idx;
        miso <= 1'b1;
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b0};
        miso <= tx_sh[6];
      end
    end else if (ser.cs_n) begin
      // Released line toggles so a stale level is never mistaken for data
      miso <= ~miso;
      cnt <= 3'h0;
    end else if (cs_q) begin
      // Every reply byte has its top bit set
      tx_sh <= 8'hC0 + idx;
      miso <= 1'b1;
    end else if (!sclk_q && ser.sclk) begin
      rx_sh <= {rx_sh[6:0], ser.mosi};
    end
  end
endmodule : spdsr_slave

// ### spdsr_top_bench.sv
// Self-checking bench for the serial port: register tasks, slave model on the pins.
// Assumes single-cycle register strobes and read data in the following cycle.
`timescale 1ns/1ps
`include "spdsr_defs.svh"
module spdsr_top_bench
  import spdsr_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  spdsr_bus_req_t req = '0;
  logic [31:0] bus_rdata;
  spdsr_ser_t ser;
  logic miso;
  logic irq;
  logic [7:0] got;
  int bad_count = 0;
  int n_tests = 0;
  int hcnt = 0;
  int hi_len = 0;
  always #20 mclk = ~mclk;
  spdsr_top uut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(bus_rdata),
    .ser_out(ser), .ser_miso(miso), .irq(irq));
  spdsr_slave peer (.mclk(mclk), .ser(ser), .miso(miso), .got(got));
  // Length of the last sclk high phase in mclk cycles
  always @(posedge mclk) begin
    if (ser.sclk === 1'b1) begin
      hcnt++;
    end else if (hcnt != 0) begin
      hi_len = hcnt;
      hcnt = 0;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d & m);
  endtask : rc
  task automatic wait_idle();
    logic [31:0] d;
    int k;
    for (k = 0; k < 500; k++) begin
      rd(`SPDSR_A_STAT, d);
      if (d[4] === 1'b0) break;
    end
    if (k == 500) chk("idle wait", 32'h0, 32'h1);
  endtask : wait_idle
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rc("status", `SPDSR_A_STAT, 32'h3);
    rc("mask", `SPDSR_A_MASK, 32'h0);
    rc("raw", `SPDSR_A_RAW, 32'h0);
    rc("masked", `SPDSR_A_MIS, 32'h0);
    wr(`SPDSR_A_STAT, 32'hFFFFFFFF);
    rc("status", `SPDSR_A_STAT, 32'h3);
    wr(`SPDSR_A_MASK, 32'hFFFFFFFF);
    rc("mask", `SPDSR_A_MASK, 32'h3F);
    wr(`SPDSR_A_PRESC, 32'hFFFFFF08);
    rc("prescale", `SPDSR_A_PRESC, 32'h8);
    rc("unmapped", 8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`SPDSR_A_CTRL0, 32'h7);
    wr(`SPDSR_A_DATA, 32'hABCDEF5A);
    rc("status", `SPDSR_A_STAT, 32'h12);
    rc("raw", `SPDSR_A_RAW, 32'h08);
    chk("irq", 32'h1, {31'h0, irq});
    repeat (50) @(posedge mclk);
    chk("cs idle", 32'h1, {31'h0, ser.cs_n});
    wr(`SPDSR_A_CTRL1, 32'h2);
    wait_idle();
    chk("mosi frame", 32'h5A, {24'h0, got});
    chk("sclk high", 32'h4, hi_len);
    rc("status", `SPDSR_A_STAT, 32'h7);
    rc("data", `SPDSR_A_DATA, 32'hC0);
    wr(`SPDSR_A_CTRL0, 32'h107);
    wr(`SPDSR_A_DATA, 32'h3C);
    wait_idle();
    chk("mosi frame", 32'h3C, {24'h0, got});
    chk("sclk high", 32'h8, hi_len);
    rc("data", `SPDSR_A_DATA, 32'hC1);
    wr(`SPDSR_A_CTRL1, 32'h0);
    wr(`SPDSR_A_CTRL0, 32'h7);
    for (int i = 0; i < 8; i++) wr(`SPDSR_A_DATA, 32'h10 + i);
    rc("status", `SPDSR_A_STAT, 32'h10);
    wr(`SPDSR_A_CTRL1, 32'h2);
    wait_idle();
    rc("status", `SPDSR_A_STAT, 32'hF);
    wr(`SPDSR_A_DATA, 32'h99);
    wait_idle();
    chk("mosi frame", 32'h99, {24'h0, got});
    repeat (70) @(posedge mclk);
    rc("raw", `SPDSR_A_RAW, 32'h27);
    wr(`SPDSR_A_MASK, 32'h3);
    rc("masked", `SPDSR_A_MIS, 32'h3);
    wr(`SPDSR_A_CLR, 32'h1);
    rc("overrun", `SPDSR_A_RAW, 32'h0, 32'h1);
    wr(`SPDSR_A_MASK, 32'h0);
    @(posedge mclk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 5; i++) rc("data", `SPDSR_A_DATA, 32'hC2 + i);
    for (int c = 0; c < 3; c++) begin
      wr(`SPDSR_A_CTRL1, 32'h2 | (c << 7));
      rc("rx level", `SPDSR_A_RAW, (c == 0) ? 32'h4 : 32'h0, 32'h4);
    end
    for (int i = 0; i < 3; i++) rc("data", `SPDSR_A_DATA, 32'hC7 + i);
    rc("status", `SPDSR_A_STAT, 32'h3);
    wr(`SPDSR_A_PRESC, 32'h2);
    wr(`SPDSR_A_DATA, 32'h66);
    wait_idle();
    chk("mosi frame", 32'h66, {24'h0, got});
    chk("sclk high", 32'h1, hi_len);
    wrap_up();
  end
endmodule : spdsr_top_bench
